// *** core/ep_mode_pkg.sv ***
package ep_mode_pkg;

  // endpoint count: control endpoint plus two data endpoints
  localparam logic [1:0] NUM_EP = 2'h3;
  localparam logic [1:0] CTRL_EP = 2'h0;

  // register offsets on the firmware port
  localparam logic [3:0] OFS_MODE_BASE = 4'h0; // ep n mode at base + n
  localparam logic [3:0] OFS_COUNT_BASE = 4'h4; // ep n count at base + n
  localparam logic [3:0] OFS_INT_STAT = 4'h8;
  localparam logic [3:0] OFS_INT_MASK = 4'h9;

  // field positions inside mode and count registers
  localparam int MODE_STALL_BIT = 7;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 3;
  localparam int COUNT_MSB = 3;

  // reset values
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam logic [2:0] INT_RESET = 3'h0;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // mode encodings
  localparam logic [3:0] MODE_DISABLE = 4'h0;
  localparam logic [3:0] MODE_NAK_INOUT = 4'h1;
  localparam logic [3:0] MODE_STATUS_OUT = 4'h2;
  localparam logic [3:0] MODE_STALL_INOUT = 4'h3;
  localparam logic [3:0] MODE_IGNORE_INOUT = 4'h4;
  localparam logic [3:0] MODE_RSVD_OUT = 4'h5;
  localparam logic [3:0] MODE_STATUS_IN = 4'h6;
  localparam logic [3:0] MODE_RSVD_IN = 4'h7;
  localparam logic [3:0] MODE_NAK_OUT = 4'h8;
  localparam logic [3:0] MODE_ACK_OUT = 4'h9;
  localparam logic [3:0] MODE_NAKOUT_STIN = 4'hA;
  localparam logic [3:0] MODE_ACKOUT_NAKIN = 4'hB;
  localparam logic [3:0] MODE_NAK_IN = 4'hC;
  localparam logic [3:0] MODE_ACK_IN = 4'hD;
  localparam logic [3:0] MODE_NAKIN_STOUT = 4'hE;
  localparam logic [3:0] MODE_ACKIN_STOUT = 4'hF;

  // zero-length status out data must carry this toggle
  localparam logic STATUS_TOGGLE = 1'b1;
  localparam logic [3:0] ZERO_LEN = 4'h0;

  typedef enum logic [1:0] {
    PID_SETUP = 2'b00,
    PID_IN = 2'b01,
    PID_OUT = 2'b10
  } pid_type;

  typedef enum logic [1:0] {
    RESP_ACK = 2'b00,
    RESP_NAK = 2'b01,
    RESP_STALL = 2'b10,
    RESP_DATA = 2'b11
  } resp_kind_type;

  typedef enum logic [2:0] {
    ACT_IGNORE = 3'b000,
    ACT_NAK = 3'b001,
    ACT_STALL = 3'b010,
    ACT_ACK = 3'b011,
    ACT_CHECK = 3'b100,
    ACT_TX0 = 3'b101,
    ACT_TXCNT = 3'b110
  } act_type;

  typedef enum logic [1:0] {
    FSM_IDLE = 2'b00,
    FSM_WAIT_DATA = 2'b01,
    FSM_WAIT_ACK = 2'b10
  } fsm_type;

  typedef struct packed {
    pid_type pid;
    logic [1:0] ep;
  } token_type;

  typedef struct packed {
    logic [3:0] len;
    logic toggle;
    logic valid;
  } rx_data_type;

  typedef struct packed {
    resp_kind_type kind;
    logic [3:0] len;
  } resp_type;

  typedef struct packed {
    fsm_type fsm;
    logic [1:0] ep;
    pid_type pid;
    logic [2:0][3:0] mode;
    logic [2:0] stall;
    logic [2:0][3:0] count;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic [7:0] rdata;
    logic resp_valid;
    resp_type resp;
    logic irq;
  } state_type;

endpackage

// *** core/usb_protocol_engine.sv ***
// Functional notes
// - mode 0000 gives no answer at all to SETUP, IN or OUT.
// - mode 0001 accepts SETUP and NAKs every IN and OUT.
// - control endpoint SETUP ACK forces mode 0001 unless it was 0000.
// - mode 1011 accepts SETUP, NAKs IN, ACKs OUT then becomes 0001.
// - 0010 stalls IN, checks OUT; 0110 zero IN, stall OUT; 1010 zero IN, NAK OUT.
// - 0011 stalls IN and OUT; 0100 ignores IN and OUT; both accept SETUP.
// - 1000 NAKs OUT; 1001 ACKs OUT or stalls, ACK moves to 1000.
// - 1100 NAKs IN; 1101 sends count or stalls, host ACK moves to 1100.
// - 1110 NAKs IN, checks OUT; 1111 sends count, host ACK moves to 1110.
// - checked OUT is ACKed only when zero length with toggle 1.
// - counted IN sends the four-bit byte count of that endpoint.
// - zero-length IN sends a data packet with no payload.
// - ignored tokens get no handshake; accepted valid SETUP gets ACK.
// - mode field is bits 3 to 0 of each endpoint mode register.
// - SETUP ACK only when the SETUP transaction is valid.
// - all modes reset to 0000 and stay there until firmware writes.
// - interrupt on valid completion or on bad data to enabled endpoint.
`timescale 1ns/1ps
`default_nettype none

module usb_protocol_engine (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tok_valid,
  input wire ep_mode_pkg::token_type tok,
  input wire logic data_done,
  input wire ep_mode_pkg::rx_data_type rx,
  input wire logic host_ack,
  output logic resp_valid,
  output ep_mode_pkg::resp_type resp,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // response tables

  // answer to an IN token for a given mode and stall bit
  function automatic ep_mode_pkg::act_type in_act(input logic [3:0] m,
                                                  input logic s);
    case (m)
      ep_mode_pkg::MODE_NAK_INOUT: in_act = ep_mode_pkg::ACT_NAK;
      ep_mode_pkg::MODE_STATUS_OUT: in_act = ep_mode_pkg::ACT_STALL;
      ep_mode_pkg::MODE_STALL_INOUT: in_act = ep_mode_pkg::ACT_STALL;
      ep_mode_pkg::MODE_STATUS_IN: in_act = ep_mode_pkg::ACT_TX0;
      ep_mode_pkg::MODE_RSVD_IN: in_act = ep_mode_pkg::ACT_TXCNT;
      ep_mode_pkg::MODE_NAKOUT_STIN: in_act = ep_mode_pkg::ACT_TX0;
      ep_mode_pkg::MODE_ACKOUT_NAKIN: in_act = ep_mode_pkg::ACT_NAK;
      ep_mode_pkg::MODE_NAK_IN: in_act = ep_mode_pkg::ACT_NAK;
      ep_mode_pkg::MODE_ACK_IN: begin
        in_act = s ? ep_mode_pkg::ACT_STALL : ep_mode_pkg::ACT_TXCNT;
      end
      ep_mode_pkg::MODE_NAKIN_STOUT: in_act = ep_mode_pkg::ACT_NAK;
      ep_mode_pkg::MODE_ACKIN_STOUT: in_act = ep_mode_pkg::ACT_TXCNT;
      default: in_act = ep_mode_pkg::ACT_IGNORE;
    endcase
  endfunction

  // answer to an OUT token for a given mode and stall bit
  function automatic ep_mode_pkg::act_type out_act(input logic [3:0] m,
                                                   input logic s);
    case (m)
      ep_mode_pkg::MODE_NAK_INOUT: out_act = ep_mode_pkg::ACT_NAK;
      ep_mode_pkg::MODE_STATUS_OUT: out_act = ep_mode_pkg::ACT_CHECK;
      ep_mode_pkg::MODE_STALL_INOUT: out_act = ep_mode_pkg::ACT_STALL;
      ep_mode_pkg::MODE_RSVD_OUT: out_act = ep_mode_pkg::ACT_ACK;
      ep_mode_pkg::MODE_STATUS_IN: out_act = ep_mode_pkg::ACT_STALL;
      ep_mode_pkg::MODE_NAK_OUT: out_act = ep_mode_pkg::ACT_NAK;
      ep_mode_pkg::MODE_ACK_OUT: begin
        out_act = s ? ep_mode_pkg::ACT_STALL : ep_mode_pkg::ACT_ACK;
      end
      ep_mode_pkg::MODE_NAKOUT_STIN: out_act = ep_mode_pkg::ACT_NAK;
      ep_mode_pkg::MODE_ACKOUT_NAKIN: out_act = ep_mode_pkg::ACT_ACK;
      ep_mode_pkg::MODE_NAKIN_STOUT: out_act = ep_mode_pkg::ACT_CHECK;
      ep_mode_pkg::MODE_ACKIN_STOUT: out_act = ep_mode_pkg::ACT_CHECK;
      default: out_act = ep_mode_pkg::ACT_IGNORE;
    endcase
  endfunction

  // modes that take a SETUP token
  function automatic logic setup_ok(input logic [3:0] m);
    case (m)
      ep_mode_pkg::MODE_NAK_INOUT,
      ep_mode_pkg::MODE_STATUS_OUT,
      ep_mode_pkg::MODE_STALL_INOUT,
      ep_mode_pkg::MODE_IGNORE_INOUT,
      ep_mode_pkg::MODE_STATUS_IN,
      ep_mode_pkg::MODE_NAKOUT_STIN,
      ep_mode_pkg::MODE_ACKOUT_NAKIN,
      ep_mode_pkg::MODE_NAKIN_STOUT,
      ep_mode_pkg::MODE_ACKIN_STOUT: setup_ok = 1'b1;
      default: setup_ok = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  ep_mode_pkg::state_type st;
  ep_mode_pkg::state_type next_st;

  ////////////////////////////////////////////////////////////////////////////
  // next state: register port first, then protocol, so the engine's own
  // mode update wins over a firmware write landing in the same cycle

  always_comb begin
    logic [2:0] set_ev;
    logic [2:0] clr_ev;
    logic [3:0] m;
    logic s;
    ep_mode_pkg::act_type a;
    set_ev = 3'h0;
    clr_ev = 3'h0;
    m = ep_mode_pkg::MODE_RESET;
    s = 1'b0;
    a = ep_mode_pkg::ACT_IGNORE;
    next_st = st;
    next_st.resp_valid = 1'b0;
    next_st.rdata = ep_mode_pkg::RDATA_IDLE;

    // firmware writes
    if (reg_wr) begin
      for (int i = 0; i < 3; i++) begin
        if (reg_addr == ep_mode_pkg::OFS_MODE_BASE + 4'(i)) begin
          next_st.mode[i] = reg_wdata[ep_mode_pkg::MODE_MSB:0];
          next_st.stall[i] = reg_wdata[ep_mode_pkg::MODE_STALL_BIT];
        end
        if (reg_addr == ep_mode_pkg::OFS_COUNT_BASE + 4'(i)) begin
          next_st.count[i] = reg_wdata[ep_mode_pkg::COUNT_MSB:0];
        end
      end
      if (reg_addr == ep_mode_pkg::OFS_INT_STAT) begin
        clr_ev = reg_wdata[2:0];
      end
      if (reg_addr == ep_mode_pkg::OFS_INT_MASK) begin
        next_st.int_mask = reg_wdata[2:0];
      end
    end

    // firmware reads, answered in the following cycle only
    if (reg_rd) begin
      for (int i = 0; i < 3; i++) begin
        if (reg_addr == ep_mode_pkg::OFS_MODE_BASE + 4'(i)) begin
          next_st.rdata = {st.stall[i], 3'h0, st.mode[i]};
        end
        if (reg_addr == ep_mode_pkg::OFS_COUNT_BASE + 4'(i)) begin
          next_st.rdata = {4'h0, st.count[i]};
        end
      end
      if (reg_addr == ep_mode_pkg::OFS_INT_STAT) begin
        next_st.rdata = {5'h00, st.int_stat};
      end
      if (reg_addr == ep_mode_pkg::OFS_INT_MASK) begin
        next_st.rdata = {5'h00, st.int_mask};
      end
    end

    // a fresh token always wins: the host has moved on from any open one
    if (tok_valid) begin
      next_st.fsm = ep_mode_pkg::FSM_IDLE;
      next_st.ep = tok.ep;
      next_st.pid = tok.pid;
      if (tok.ep < ep_mode_pkg::NUM_EP) begin
        m = next_st.mode[tok.ep];
        s = next_st.stall[tok.ep];
        case (tok.pid)
          ep_mode_pkg::PID_SETUP: begin
            if (setup_ok(m)) begin
              next_st.fsm = ep_mode_pkg::FSM_WAIT_DATA;
            end
          end
          ep_mode_pkg::PID_IN: begin
            a = in_act(m, s);
            next_st.resp.len = ep_mode_pkg::ZERO_LEN;
            case (a)
              ep_mode_pkg::ACT_NAK: begin
                next_st.resp_valid = 1'b1;
                next_st.resp.kind = ep_mode_pkg::RESP_NAK;
                set_ev[tok.ep] = 1'b1;
              end
              ep_mode_pkg::ACT_STALL: begin
                next_st.resp_valid = 1'b1;
                next_st.resp.kind = ep_mode_pkg::RESP_STALL;
                set_ev[tok.ep] = 1'b1;
              end
              ep_mode_pkg::ACT_TX0: begin
                next_st.resp_valid = 1'b1;
                next_st.resp.kind = ep_mode_pkg::RESP_DATA;
                next_st.fsm = ep_mode_pkg::FSM_WAIT_ACK;
                set_ev[tok.ep] = 1'b1;
              end
              ep_mode_pkg::ACT_TXCNT: begin
                next_st.resp_valid = 1'b1;
                next_st.resp.kind = ep_mode_pkg::RESP_DATA;
                next_st.resp.len = next_st.count[tok.ep];
                next_st.fsm = ep_mode_pkg::FSM_WAIT_ACK;
              end
              default: begin
                next_st.resp_valid = 1'b0;
              end
            endcase
          end
          ep_mode_pkg::PID_OUT: begin
            if (out_act(m, s) != ep_mode_pkg::ACT_IGNORE) begin
              next_st.fsm = ep_mode_pkg::FSM_WAIT_DATA;
            end
          end
          default: begin
            next_st.fsm = ep_mode_pkg::FSM_IDLE;
          end
        endcase
      end
    end else begin
      case (st.fsm)
        ep_mode_pkg::FSM_WAIT_DATA: begin
          if (data_done) begin
            next_st.fsm = ep_mode_pkg::FSM_IDLE;
            m = next_st.mode[st.ep];
            s = next_st.stall[st.ep];
            next_st.resp.len = ep_mode_pkg::ZERO_LEN;
            set_ev[st.ep] = 1'b1;
            if (!rx.valid) begin
              next_st.resp_valid = 1'b0;
            end else if (st.pid == ep_mode_pkg::PID_SETUP) begin
              next_st.resp_valid = 1'b1;
              next_st.resp.kind = ep_mode_pkg::RESP_ACK;
              if (st.ep == ep_mode_pkg::CTRL_EP &&
                  m != ep_mode_pkg::MODE_DISABLE) begin
                next_st.mode[st.ep] = ep_mode_pkg::MODE_NAK_INOUT;
              end
            end else begin
              a = out_act(m, s);
              if (a == ep_mode_pkg::ACT_CHECK) begin
                // only an empty DATA1 packet closes the status stage
                if (rx.len == ep_mode_pkg::ZERO_LEN &&
                    rx.toggle == ep_mode_pkg::STATUS_TOGGLE) begin
                  a = ep_mode_pkg::ACT_ACK;
                end else begin
                  a = ep_mode_pkg::ACT_STALL;
                end
              end
              next_st.resp_valid = (a != ep_mode_pkg::ACT_IGNORE);
              case (a)
                ep_mode_pkg::ACT_NAK: begin
                  next_st.resp.kind = ep_mode_pkg::RESP_NAK;
                end
                ep_mode_pkg::ACT_STALL: begin
                  next_st.resp.kind = ep_mode_pkg::RESP_STALL;
                end
                default: begin
                  next_st.resp.kind = ep_mode_pkg::RESP_ACK;
                end
              endcase
              if (a == ep_mode_pkg::ACT_ACK) begin
                if (m == ep_mode_pkg::MODE_ACKOUT_NAKIN) begin
                  next_st.mode[st.ep] = ep_mode_pkg::MODE_NAK_INOUT;
                end
                if (m == ep_mode_pkg::MODE_ACK_OUT) begin
                  next_st.mode[st.ep] = ep_mode_pkg::MODE_NAK_OUT;
                end
              end
            end
          end
        end
        ep_mode_pkg::FSM_WAIT_ACK: begin
          if (host_ack) begin
            next_st.fsm = ep_mode_pkg::FSM_IDLE;
            m = next_st.mode[st.ep];
            set_ev[st.ep] = 1'b1;
            if (m == ep_mode_pkg::MODE_ACK_IN) begin
              next_st.mode[st.ep] = ep_mode_pkg::MODE_NAK_IN;
            end
            if (m == ep_mode_pkg::MODE_ACKIN_STOUT) begin
              next_st.mode[st.ep] = ep_mode_pkg::MODE_NAKIN_STOUT;
            end
          end
        end
        default: begin
          next_st.fsm = ep_mode_pkg::FSM_IDLE;
        end
      endcase
    end

    // set beats a simultaneous write-one clear
    next_st.int_stat = (st.int_stat & ~clr_ev) | set_ev;
    next_st.irq = |(next_st.int_stat & next_st.int_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st <= '0;
      st.fsm <= ep_mode_pkg::FSM_IDLE;
      st.mode <= {3{ep_mode_pkg::MODE_RESET}};
      st.count <= {3{ep_mode_pkg::COUNT_RESET}};
      st.int_stat <= ep_mode_pkg::INT_RESET;
      st.int_mask <= ep_mode_pkg::INT_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign resp_valid = st.resp_valid;
  assign resp = st.resp;
  assign irq = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  a_disabled_silent: assert property (
    tok_valid && tok.ep < ep_mode_pkg::NUM_EP && !reg_wr &&
    st.mode[tok.ep] == ep_mode_pkg::MODE_DISABLE
    |=> !resp_valid ##1 !resp_valid [*2])
    else $error("disabled endpoint answered a token");

  a_nak_in_mode: assert property (
    tok_valid && !reg_wr && tok.pid == ep_mode_pkg::PID_IN &&
    tok.ep < ep_mode_pkg::NUM_EP &&
    st.mode[tok.ep] == ep_mode_pkg::MODE_NAK_INOUT
    |=> resp_valid && resp.kind == ep_mode_pkg::RESP_NAK)
    else $error("NAK mode did not NAK an IN");

  a_ctrl_setup_mode: assert property (
    resp_valid && resp.kind == ep_mode_pkg::RESP_ACK &&
    st.pid == ep_mode_pkg::PID_SETUP && st.ep == ep_mode_pkg::CTRL_EP
    |-> st.mode[0] == ep_mode_pkg::MODE_NAK_INOUT)
    else $error("control SETUP ACK did not force NAK mode");

  a_ack_out_mode: assert property (
    !tok_valid && !reg_wr && data_done && rx.valid &&
    st.fsm == ep_mode_pkg::FSM_WAIT_DATA &&
    st.pid == ep_mode_pkg::PID_OUT &&
    st.mode[st.ep] == ep_mode_pkg::MODE_ACKOUT_NAKIN
    |=> resp.kind == ep_mode_pkg::RESP_ACK &&
        st.mode[st.ep] == ep_mode_pkg::MODE_NAK_INOUT)
    else $error("mode 1011 OUT ACK did not return to NAK mode");

  a_check_out_len: assert property (
    !tok_valid && data_done && rx.valid && rx.len != ep_mode_pkg::ZERO_LEN &&
    st.fsm == ep_mode_pkg::FSM_WAIT_DATA && st.pid == ep_mode_pkg::PID_OUT &&
    st.mode[st.ep] == ep_mode_pkg::MODE_NAKIN_STOUT
    |=> resp_valid && resp.kind == ep_mode_pkg::RESP_STALL)
    else $error("checked OUT with data was not stalled");

  a_in_count_len: assert property (
    tok_valid && !reg_wr && tok.pid == ep_mode_pkg::PID_IN &&
    tok.ep < ep_mode_pkg::NUM_EP && !st.stall[tok.ep] &&
    st.mode[tok.ep] == ep_mode_pkg::MODE_ACK_IN
    |=> resp_valid && resp.kind == ep_mode_pkg::RESP_DATA &&
        resp.len == $past(st.count[tok.ep]))
    else $error("counted IN sent the wrong length");

  a_setup_valid_ack: assert property (
    resp_valid && resp.kind == ep_mode_pkg::RESP_ACK &&
    st.pid == ep_mode_pkg::PID_SETUP
    |-> $past(data_done) && $past(rx.valid))
    else $error("SETUP ACK without a valid transaction");

  a_reset_modes: assert property (
    $rose(resetn) |-> st.mode == '0 && !resp_valid && !irq)
    else $error("modes not disabled after reset");

  a_irq_level: assert property (
    irq == |(st.int_stat & st.int_mask))
    else $error("interrupt output disagrees with status and mask");

  // a NAK or STALL handshake must leave its endpoint's status bit set
  a_refuse_sets_status: assert property (
    resp_valid && resp.kind != ep_mode_pkg::RESP_ACK &&
    resp.kind != ep_mode_pkg::RESP_DATA |-> st.int_stat[st.ep])
    else $error("refusing handshake did not set endpoint status");

endmodule

`default_nettype wire

// *** dv/usb_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// host side of the token link: one-cycle pulses out, replies watched
module usb_host_model (
  input wire logic ref_clk,
  output logic tok_valid,
  output ep_mode_pkg::token_type tok,
  output logic data_done,
  output ep_mode_pkg::rx_data_type rx,
  output logic host_ack,
  input wire logic resp_valid,
  input wire ep_mode_pkg::resp_type resp
);

  // idle values from time zero
  initial begin
    tok_valid = 1'b0;
    tok = '0;
    data_done = 1'b0;
    rx = '0;
    host_ack = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // qualified lines flip after the pulse so a stale value never matches
  task automatic send_token(input logic [3:0] t);
    @(posedge ref_clk);
    tok_valid <= 1'b1;
    tok <= ep_mode_pkg::token_type'(t);
    @(posedge ref_clk);
    tok_valid <= 1'b0;
    tok <= ep_mode_pkg::token_type'(~t);
  endtask

  // data packet end, sent at least one cycle after its token
  task automatic send_data(input logic [5:0] d);
    @(posedge ref_clk);
    data_done <= 1'b1;
    rx <= ep_mode_pkg::rx_data_type'(d);
    @(posedge ref_clk);
    data_done <= 1'b0;
    rx <= ep_mode_pkg::rx_data_type'(~d);
  endtask

  // acknowledge of a data packet the device sent
  task automatic send_ack();
    @(posedge ref_clk);
    host_ack <= 1'b1;
    @(posedge ref_clk);
    host_ack <= 1'b0;
  endtask

  // reply as {cycle it stands in, resp}; a late reply shows a cycle above 1
  // the reply is registered on the request's own edge, so look before waiting
  task automatic wait_resp(output logic [7:0] r);
    r = 8'h00;
    for (int i = 1; i <= 3; i++) begin
      #1;
      if (resp_valid === 1'b1 && r === 8'h00) r = {2'(i), resp};
      @(posedge ref_clk);
    end
  endtask

endmodule

`default_nettype wire

// *** dv/test_usb_endpoint_mode_responder.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_usb_endpoint_mode_responder;

  localparam logic [1:0] P_SETUP = ep_mode_pkg::PID_SETUP;
  localparam logic [1:0] P_IN = ep_mode_pkg::PID_IN;
  localparam logic [1:0] P_OUT = ep_mode_pkg::PID_OUT;
  localparam logic [5:0] GOOD = 6'h03; // zero length, toggle 1, crc ok
  localparam logic [5:0] BAD = 6'h02; // crc failure
  localparam logic [7:0] E_ACK = {2'h1, ep_mode_pkg::RESP_ACK, 4'h0};
  localparam logic [7:0] E_NAK = {2'h1, ep_mode_pkg::RESP_NAK, 4'h0};
  localparam logic [7:0] E_STALL = {2'h1, ep_mode_pkg::RESP_STALL, 4'h0};
  localparam logic [7:0] E_DATA = {2'h1, ep_mode_pkg::RESP_DATA, 4'h0};

  logic ref_clk = 1'b0;
  logic resetn;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic tok_valid;
  ep_mode_pkg::token_type tok;
  logic data_done;
  ep_mode_pkg::rx_data_type rx;
  logic host_ack;
  logic resp_valid;
  ep_mode_pkg::resp_type resp;
  logic irq;
  int fails = 0;
  int total_checks = 0;

  usb_protocol_engine usb_protocol_engine_i (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tok_valid(tok_valid), .tok(tok),
    .data_done(data_done), .rx(rx), .host_ack(host_ack),
    .resp_valid(resp_valid), .resp(resp), .irq(irq)
  );

  usb_host_model usb_host_model_i (
    .ref_clk(ref_clk), .tok_valid(tok_valid), .tok(tok),
    .data_done(data_done), .rx(rx), .host_ack(host_ack),
    .resp_valid(resp_valid), .resp(resp)
  );

  // 125 MHz
  always #4 ref_clk = ~ref_clk;

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // firmware port: strobes last one cycle, read data stands one cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  // one transaction; SETUP and OUT carry a data packet
  task automatic txc(input logic [1:0] p, input logic [1:0] ep,
                     input logic [5:0] d, input logic [7:0] exp);
    logic [7:0] r;
    usb_host_model_i.send_token({p, ep});
    if (p != P_IN) usb_host_model_i.send_data(d);
    usb_host_model_i.wait_resp(r);
    check(r, exp);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // every register reads zero out of reset, disabled endpoints stay silent
  task automatic t_reset();
    for (int a = 0; a < 16; a++) rdc(4'(a), 8'h00);
    for (int k = 0; k < 3; k++) txc(2'(k), 2'h2, GOOD, 8'h00);
    wr(4'hF, 8'hFF);
    rdc(4'hF, 8'h00);
    rdc(4'h2, 8'h00);
    rdc(4'h8, 8'h00);
  endtask

  // all sixteen encodings against all three tokens on a data endpoint
  task automatic t_mode_table();
    logic [11:0] tbl [16];
    logic [7:0] ex [6];
    logic [3:0] nm;
    tbl = '{12'h000, 12'h122, 12'h131, 12'h133, 12'h100, 12'h001,
            12'h153, 12'h040, 12'h002, 12'h001, 12'h152, 12'h121,
            12'h020, 12'h040, 12'h121, 12'h141};
    ex = '{8'h00, E_ACK, E_NAK, E_STALL, E_DATA | 8'h09, E_DATA};
    wr(4'h5, 8'h09);
    for (int m = 0; m < 16; m++) begin
      for (int k = 0; k < 3; k++) begin
        wr(4'h1, {4'h0, 4'(m)});
        txc(2'(k), 2'h1, GOOD, ex[tbl[m][(2 - k) * 4 +: 4]]);
        nm = (k == 2 && m == 9) ? 4'h8 : (k == 2 && m == 11) ? 4'h1 : 4'(m);
        rdc(4'h1, {4'h0, nm});
      end
    end
  endtask // table also

  // control endpoint falls back to nak mode after a good setup only
  task automatic t_setup_force();
    wr(4'h0, 8'h0F);
    txc(P_SETUP, 2'h0, BAD, 8'h00);
    rdc(4'h0, 8'h0F);
    txc(P_SETUP, 2'h0, GOOD, E_ACK);
    rdc(4'h0, 8'h01);
    wr(4'h0, 8'h04);
    txc(P_SETUP, 2'h0, GOOD, E_ACK);
    rdc(4'h0, 8'h01);
    wr(4'h0, 8'h00);
    txc(P_SETUP, 2'h0, GOOD, 8'h00);
    rdc(4'h0, 8'h00);
  endtask

  // stall bit turns ack modes 1001 and 1101 into stall and blocks the mode change
  task automatic t_stall_bit();
    wr(4'h2, 8'h89);
    txc(P_OUT, 2'h2, GOOD, E_STALL);
    rdc(4'h2, 8'h89);
    wr(4'h2, 8'h8D);
    txc(P_IN, 2'h2, GOOD, E_STALL);
    rdc(4'h2, 8'h8D);
    wr(4'h2, 8'h09);
    txc(P_OUT, 2'h2, 6'h11, E_ACK);
    rdc(4'h2, 8'h08);
  endtask

  // counted replies at the largest count and at count 3, then the host ack moves the mode
  task automatic t_in_ack();
    wr(4'h6, 8'h0F);
    wr(4'h2, 8'h0D);
    txc(P_IN, 2'h2, GOOD, E_DATA | 8'h0F);
    usb_host_model_i.send_ack();
    rdc(4'h2, 8'h0C);
    wr(4'h4, 8'h03);
    wr(4'h0, 8'h0F);
    txc(P_IN, 2'h0, GOOD, E_DATA | 8'h03);
    usb_host_model_i.send_ack();
    rdc(4'h0, 8'h0E);
    rdc(4'h4, 8'h03);
  endtask

  // status out: only zero length with toggle 1 is acked
  task automatic t_check_out();
    wr(4'h0, 8'h0E);
    txc(P_OUT, 2'h0, 6'h13, E_STALL);
    txc(P_OUT, 2'h0, 6'h01, E_STALL);
    txc(P_OUT, 2'h0, BAD, 8'h00);
    txc(P_OUT, 2'h0, GOOD, E_ACK);
    rdc(4'h0, 8'h0E);
  endtask

  // sticky status, mask, write-one-to-clear, bad crc still flagged
  task automatic t_irq();
    wr(4'h8, 8'h07);
    rdc(4'h8, 8'h00);
    wr(4'h9, 8'h02);
    rdc(4'h9, 8'h02);
    check({7'h0, irq}, 8'h00);
    wr(4'h1, 8'h01);
    txc(P_IN, 2'h1, GOOD, E_NAK);
    rdc(4'h8, 8'h02);
    check({7'h0, irq}, 8'h01);
    wr(4'h8, 8'h02);
    rdc(4'h8, 8'h00);
    check({7'h0, irq}, 8'h00);
    wr(4'h0, 8'h01);
    txc(P_SETUP, 2'h0, BAD, 8'h00);
    rdc(4'h8, 8'h01);
    check({7'h0, irq}, 8'h00);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_mode_table();
    t_setup_force();
    t_stall_bit();
    t_in_ack();
    t_check_out();
    t_irq();
    print_verdict();
  end

  // the run needs about 730 cycles; a hang is cut well beyond that
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end

endmodule

`default_nettype wire
